// ===== puqoc_ctrl.sv
// power-up qualification and input overvoltage lockout control
// How it works
// - fuses copied only after supply rising crossing
// - below threshold: unpowered, nothing happens
// - shutdown select 0: overvoltage raises interrupt only
// - shutdown select 1: overvoltage starts power-down
// - monitor enable gates all overvoltage events
// - enable, select, debounce loaded from fuses
// - fused select 0: power-up continues, interrupt
// - fused select 1: power-up aborted to Off
// - debounce codes 10, 100, 1000 microseconds
// - first slot within 1.5 ms of supply
// - fuse load done within 600 microseconds
// - low-power off: slot within 800 microseconds
// - each power cycle clears low-power-off flag
// - flag writable in Run, kept until cycle
// - mode 0: high pin level powers up
// - mode 1: falling edge held low debounced
// - power-up needs supply, thermal, error flags clear
//
// The address map and the strobed register port were chosen for this implementation.
`default_nettype none
module puqoc_ctrl
   import puqoc_pkg::*;
#(
   parameter int unsigned FUSE_LOAD_CYCLES = 100, // cycles to read fuses, under the 600 us bound
   parameter int unsigned SELFTEST_CYCLES = 200, // cycles to bias and self-test from low-power off
   parameter int unsigned POWER_ON_DEBOUNCE_TIME_CYCLES = 1000 // power-on pin debounce in edge mode
) (
   input wire logic i_core_clk, // 40 MHz core clock
   input wire logic i_rst_n, // async reset, active low
   input wire logic i_supply_operate_threshold, // comparator: supply above operate threshold
   input wire logic i_input_overvoltage_lockout, // comparator: supply above lockout
   input wire logic i_thermal_shutdown, // comparator: junction above shutdown
   input wire logic i_power_on_pin, // power-on pin level
   input wire puqoc_pkg::puqoc_fuse_t i_fuse, // fuse array contents
   input wire logic i_trim_error_flag, // trim error
   input wire logic i_fuse_error_flag, // fuse error
   input wire logic i_selftest_error_flag, // self-test error
   input wire logic i_pd_done, // power-down sequence finished (same clock)
   input wire logic [7:0] i_addr, // register byte address
   input wire logic [31:0] i_wdata, // write data
   input wire logic i_wr, // write strobe
   input wire logic i_rd, // read strobe
   output logic [31:0] o_rdata, // read data, cycle after strobe
   output logic o_fuse_loaded, // mirror registers valid
   output logic o_seq_start, // pulse: first power-up slot begins
   output logic o_pd_request, // level: power-down requested
   output logic o_low_power_off_state, // in Off with low-power flag clear
   output logic o_irq // level interrupt
);
   // two-flop synchronisers for the asynchronous comparator and pin levels
   logic [3:0] sync1; // first stage, read only by sync2
   logic [3:0] sync2; // second stage, safe to use
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= {i_supply_operate_threshold, i_input_overvoltage_lockout,
                   i_thermal_shutdown, i_power_on_pin};
         sync2 <= sync1;
      end
   end
   logic supply_ok; // supply above operate threshold
   logic ov_raw; // unfiltered overvoltage
   logic tsd; // thermal shutdown
   logic pin; // power-on pin level
   assign supply_ok = sync2[3];
   assign ov_raw = sync2[2];
   assign tsd = sync2[1];
   assign pin = sync2[0];

   // bus request bundled for decode
   puqoc_bus_t bus;
   assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

   // state and mirror registers
   puqoc_state_t state; // power state
   puqoc_state_t next_state; // next power state
   puqoc_fuse_t mirror; // fuse mirror
   logic ov_monitor_enable; // functional enable
   logic ov_shutdown_select; // functional reaction select
   logic [1:0] ov_debounce_select; // functional debounce select
   logic low_power_off_flag; // set keeps internal circuits biased in Off
   logic [TMR_W-1:0] tmr; // state timer
   logic supply_prev; // supply level last cycle
   logic [IRQ_W-1:0] irq_status; // sticky events
   logic [IRQ_W-1:0] irq_mask; // unmask bits, 1 passes
   logic [IRQ_W-1:0] irq_event; // single-cycle events this cycle
   logic ov_filt; // debounced overvoltage
   logic ov_filt_prev; // for the rising edge
   logic ov_event; // qualified overvoltage event
   logic pin_prev; // pin last cycle
   logic pin_low_cnt_done; // edge mode low-hold satisfied
   logic [TMR_W-1:0] pin_low_cnt; // cycles the pin stayed low after a fall
   logic pin_armed; // falling edge seen, timing the low
   logic pwrup_event; // raw power-up event
   logic pwrup_ok; // qualifying conditions hold
   logic supply_rise; // rising crossing of operate threshold
   logic [TMR_W-1:0] dbnc_limit; // selected debounce count
   logic [TMR_W-1:0] start_limit; // cycles before first slot

   assign supply_rise = supply_ok && !supply_prev;

   // debounce count from the select; the reserved code falls back to the longest
   assign dbnc_limit = (ov_debounce_select == DBNC_10) ? TMR_W'(OV_DBNC_10_CYC) :
                       (ov_debounce_select == DBNC_100) ? TMR_W'(OV_DBNC_100_CYC) :
                       TMR_W'(OV_DBNC_1000_CYC);

   puqoc_debounce puqoc_debounce_inst (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_level(ov_raw),
      .i_limit(dbnc_limit),
      .o_level(ov_filt)
   );

   // a disabled monitor raises no event; the filter still tracks the comparator
   assign ov_event = ov_filt && !ov_filt_prev && ov_monitor_enable;

   // power-on pin qualification by mode
   assign pin_low_cnt_done = pin_armed && (pin_low_cnt + TMR_W'(1) >= TMR_W'(POWER_ON_DEBOUNCE_TIME_CYCLES));
   assign pwrup_event = mirror.power_on_pin_mode ? pin_low_cnt_done
                                                 : pin;

   // lockout blocks power-up only if monitor on and fused reaction is shutdown
   assign pwrup_ok = supply_ok && !tsd
                     && !(ov_filt && ov_monitor_enable && mirror.ov_shutdown_select)
                     && !i_trim_error_flag && !i_fuse_error_flag
                     && !i_selftest_error_flag;

   // startup time: short when biased, longer when internal circuits must wake
   assign start_limit = low_power_off_flag ? TMR_W'(1) : TMR_W'(SELFTEST_CYCLES);

   // state transitions
   always_comb begin
      next_state = state;
      unique case (state)
         ST_UNPOWERED: begin
            if (supply_rise) begin
               next_state = ST_FUSE_LOAD;
            end
         end
         ST_FUSE_LOAD: begin
            if (tmr + TMR_W'(1) >= TMR_W'(FUSE_LOAD_CYCLES)) begin
               next_state = ST_OFF;
            end
         end
         ST_OFF: begin
            if (pwrup_event && pwrup_ok) begin
               next_state = ST_STARTUP;
            end
         end
         ST_STARTUP: begin
            if (ov_event && mirror.ov_shutdown_select) begin
               next_state = ST_OFF;
            end else if (tmr + TMR_W'(1) >= start_limit) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (i_pd_done && o_pd_request) begin
               next_state = ST_OFF;
            end
         end
         default: next_state = ST_UNPOWERED;
      endcase
      if (!supply_ok) begin
         next_state = ST_UNPOWERED;
      end
   end

   // state, timer and previous-level registers
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= ST_UNPOWERED;
         tmr <= '0;
         supply_prev <= 1'b0;
         ov_filt_prev <= 1'b0;
         pin_prev <= 1'b0;
      end else begin
         state <= next_state;
         tmr <= (next_state != state) ? '0 : tmr + TMR_W'(1);
         supply_prev <= supply_ok;
         ov_filt_prev <= ov_filt;
         pin_prev <= pin;
      end
   end

   // edge mode: arm on a fall, drop the arm if the pin bounces high
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_armed <= 1'b0;
         pin_low_cnt <= '0;
      end else if (pin_prev && !pin) begin
         pin_armed <= 1'b1;
         pin_low_cnt <= '0;
      end else if (pin || pin_low_cnt_done || state != ST_OFF) begin
         pin_armed <= 1'b0;
         pin_low_cnt <= '0;
      end else if (pin_armed) begin
         pin_low_cnt <= pin_low_cnt + TMR_W'(1);
      end
   end

   // fuse mirror and functional defaults, loaded at end of fuse read
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mirror <= '0;
         ov_monitor_enable <= 1'b0;
         ov_shutdown_select <= 1'b0;
         ov_debounce_select <= DBNC_10;
      end else if (state == ST_FUSE_LOAD && next_state == ST_OFF) begin
         mirror <= i_fuse;
         ov_monitor_enable <= i_fuse.ov_monitor_enable;
         ov_shutdown_select <= i_fuse.ov_shutdown_select;
         ov_debounce_select <= i_fuse.ov_debounce_select;
      end else if (bus.wr && bus.addr == ADDR_CTRL && state == ST_RUN) begin
         ov_monitor_enable <= bus.wdata[CTRL_OV_EN];
         ov_shutdown_select <= bus.wdata[CTRL_OV_SDWN];
         ov_debounce_select <= bus.wdata[CTRL_OV_DBNC +: 2];
      end
   end

   // low-power-off flag: cleared by each power cycle, written only in Run
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         low_power_off_flag <= 1'b0;
      end else if (state == ST_UNPOWERED) begin
         low_power_off_flag <= 1'b0;
      end else if (bus.wr && bus.addr == ADDR_CTRL && state == ST_RUN) begin
         low_power_off_flag <= bus.wdata[CTRL_LPOFF];
      end
   end

   // power-down request: lockout with shutdown reaction while running
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pd_request <= 1'b0;
      end else if (state != ST_RUN) begin
         o_pd_request <= 1'b0;
      end else if (ov_event && ov_shutdown_select) begin
         o_pd_request <= 1'b1;
      end
   end

   // events: overvoltage report, startup complete, startup aborted
   always_comb begin
      irq_event = '0;
      // the interrupt-only reaction leaves the state machine running
      irq_event[IRQ_OV] = ov_event && ((state == ST_RUN && !ov_shutdown_select)
                          || (state == ST_STARTUP && !mirror.ov_shutdown_select));
      irq_event[IRQ_PWRUP] = state == ST_STARTUP && next_state == ST_RUN;
      irq_event[IRQ_ABORT] = state == ST_STARTUP && next_state == ST_OFF;
   end

   // sticky status with write-one-to-clear; a new event wins over the clear
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_status <= '0;
         irq_mask <= MASK_RESET;
      end else begin
         irq_status <= (irq_status & ~((bus.wr && bus.addr == ADDR_IRQ) ?
                        bus.wdata[IRQ_W-1:0] : '0)) | irq_event;
         if (bus.wr && bus.addr == ADDR_MASK) begin
            irq_mask <= bus.wdata[IRQ_W-1:0];
         end
      end
   end

   // read mux; unmapped addresses read zero
   logic [31:0] rd_mux; // selected read word
   assign rd_mux = (bus.addr == ADDR_CTRL) ? {27'h0, low_power_off_flag, ov_debounce_select,
                                              ov_shutdown_select, ov_monitor_enable} :
                   (bus.addr == ADDR_STATUS) ? {22'h0, mirror.power_on_pin_mode, ov_filt,
                                                 pwrup_ok, o_fuse_loaded, 1'b0, state} :
                   (bus.addr == ADDR_IRQ) ? {29'h0, irq_status} :
                   (bus.addr == ADDR_MASK) ? {29'h0, irq_mask} : 32'h0;

   // registered outputs
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 32'h0;
         o_fuse_loaded <= 1'b0;
         o_seq_start <= 1'b0;
         o_low_power_off_state <= 1'b0;
         o_irq <= 1'b0;
      end else begin
         o_rdata <= bus.rd ? rd_mux : 32'h0;
         o_fuse_loaded <= state inside {ST_OFF, ST_STARTUP, ST_RUN};
         o_seq_start <= irq_event[IRQ_PWRUP];
         o_low_power_off_state <= state == ST_OFF && !low_power_off_flag;
         o_irq <= |(irq_status & irq_mask);
      end
   end
endmodule : puqoc_ctrl
`default_nettype wire

// ===== puqoc_pkg.sv
// shared constants and carrier types for the power-up qualify and overvoltage lockout block
`default_nettype none
package puqoc_pkg;
   // clock rate in khz, used to turn times into cycles
   localparam int unsigned CLK_KHZ = 40000;
   // times in microseconds as specified
   localparam int unsigned OV_DBNC_10_US = 10;
   localparam int unsigned OV_DBNC_100_US = 100;
   localparam int unsigned OV_DBNC_1000_US = 1000;
   localparam int unsigned FUSE_LOAD_MAX_US = 600;
   localparam int unsigned SUPPLY_TO_SLOT_MAX_US = 1500;
   localparam int unsigned LPOFF_TO_SLOT_MAX_US = 800;
   // longest times round down to whole cycles
   localparam int unsigned OV_DBNC_10_CYC = OV_DBNC_10_US * CLK_KHZ / 1000;
   localparam int unsigned OV_DBNC_100_CYC = OV_DBNC_100_US * CLK_KHZ / 1000;
   localparam int unsigned OV_DBNC_1000_CYC = OV_DBNC_1000_US * CLK_KHZ / 1000;
   localparam int unsigned FUSE_LOAD_CYC = FUSE_LOAD_MAX_US * CLK_KHZ / 1000;
   localparam int unsigned SUPPLY_TO_SLOT_CYC = SUPPLY_TO_SLOT_MAX_US * CLK_KHZ / 1000;
   localparam int unsigned LPOFF_TO_SLOT_CYC = LPOFF_TO_SLOT_MAX_US * CLK_KHZ / 1000;
   // timer width covers the largest count
   localparam int unsigned TMR_W = 17;
   // debounce select encodings
   localparam logic [1:0] DBNC_10 = 2'h0;
   localparam logic [1:0] DBNC_100 = 2'h1;
   localparam logic [1:0] DBNC_1000 = 2'h2;
   localparam logic [1:0] DBNC_RSVD = 2'h3;
   // register map offsets (byte addresses, 32-bit words)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ = 8'h08;
   localparam logic [7:0] ADDR_MASK = 8'h0c;
   // control register field positions
   localparam int unsigned CTRL_OV_EN = 0;
   localparam int unsigned CTRL_OV_SDWN = 1;
   localparam int unsigned CTRL_OV_DBNC = 2;
   localparam int unsigned CTRL_LPOFF = 4;
   // interrupt bit positions
   localparam int unsigned IRQ_W = 3;
   localparam int unsigned IRQ_OV = 0;
   localparam int unsigned IRQ_PWRUP = 1;
   localparam int unsigned IRQ_ABORT = 2;
   localparam logic [IRQ_W-1:0] MASK_RESET = 3'h0;
   // fused defaults carried as one group
   typedef struct packed {
      logic ov_monitor_enable;
      logic ov_shutdown_select;
      logic [1:0] ov_debounce_select;
      logic power_on_pin_mode;
   } puqoc_fuse_t;
   // register bus request carrier
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } puqoc_bus_t;
   // power state, one-hot
   typedef enum logic [4:0] {
      ST_UNPOWERED = 5'h01,
      ST_FUSE_LOAD = 5'h02,
      ST_OFF = 5'h04,
      ST_STARTUP = 5'h08,
      ST_RUN = 5'h10
   } puqoc_state_t;
endpackage : puqoc_pkg
`default_nettype wire

// ===== puqoc_debounce.sv
// filter that passes a level only after it holds stable for a selectable count
`default_nettype none
module puqoc_debounce
   import puqoc_pkg::*;
(
   input wire logic i_core_clk, // core clock
   input wire logic i_rst_n, // async reset, active low
   input wire logic i_level, // synchronised raw level
   input wire logic [TMR_W-1:0] i_limit, // cycles the level must hold
   output logic o_level // filtered level
);
   logic [TMR_W-1:0] cnt; // cycles the raw level has differed from output
   logic differs; // raw level disagrees with filtered one
   assign differs = i_level != o_level;
   // count while differing, restart on any bounce back
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt <= '0;
         o_level <= 1'b0;
      end else if (!differs) begin
         cnt <= '0;
      end else if (cnt + TMR_W'(1) >= i_limit) begin
         o_level <= i_level;
         cnt <= '0;
      end else begin
         cnt <= cnt + TMR_W'(1);
      end
   end
endmodule : puqoc_debounce
`default_nettype wire

// ===== puqoc_ctrl_assertions.sv
// checker for power-up qualification and overvoltage lockout control
`default_nettype none
module puqoc_ctrl_checker
   import puqoc_pkg::*;
#(
   parameter int unsigned FUSE_LOAD_CYCLES = 100 // fuse read length
) (
   input wire logic i_core_clk, // core clock
   input wire logic i_rst_n, // async reset, active low
   input wire logic i_supply_operate_threshold, // supply comparator
   input wire logic i_input_overvoltage_lockout, // overvoltage comparator
   input wire logic i_thermal_shutdown, // thermal comparator
   input wire logic i_power_on_pin, // power-on pin
   input wire logic i_trim_error_flag, // trim error
   input wire logic i_fuse_error_flag, // fuse error
   input wire logic i_selftest_error_flag, // self-test error
   input wire logic o_fuse_loaded, // mirror valid
   input wire logic o_seq_start, // first slot pulse
   input wire logic o_pd_request, // power-down request
   input wire logic o_low_power_off_state // low-power off
);
   localparam logic [16:0] FUSE_MAX = 17'h5dc0; // 600 us at 40 MHz
   logic [16:0] sup_cnt; // cycles the raw supply has stayed high
   // saturating count, so a long run cannot wrap back under the bound
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sup_cnt <= 17'h0;
      end else if (!i_supply_operate_threshold) begin
         sup_cnt <= 17'h0;
      end else if (sup_cnt <= FUSE_MAX) begin
         sup_cnt <= sup_cnt + 17'h1;
      end
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // supply gone long enough to clear the synchroniser and state
   sequence supply_gone;
      !i_supply_operate_threshold [*6];
   endsequence
   // pin low before the mirror fills, so no power-up can be pending
   sequence pin_low_load;
      !i_power_on_pin [*4] ##0 $rose(o_fuse_loaded);
   endsequence
   unpowered_idle_a: assert property (supply_gone |-> !o_fuse_loaded && !o_seq_start)
      else $error("activity while supply below threshold");
   fuse_after_supply_a: assert property ($rose(o_fuse_loaded) |->
      sup_cnt >= 17'(FUSE_LOAD_CYCLES))
      else $error("mirror loaded before supply rise and fuse read");
   fuse_load_time_a: assert property (sup_cnt == FUSE_MAX |-> o_fuse_loaded)
      else $error("fuse load not done in time");
   seq_pulse_a: assert property (o_seq_start |=> !o_seq_start)
      else $error("first slot pulse longer than one cycle");
   ov_filter_a: assert property ($rose(o_pd_request) |-> $past(i_input_overvoltage_lockout, 8)
      && $past(i_input_overvoltage_lockout, 399))
      else $error("power-down without filtered overvoltage");
   pwrup_gate_a: assert property (o_seq_start |-> !i_trim_error_flag && !i_fuse_error_flag
      && !i_selftest_error_flag && !i_thermal_shutdown)
      else $error("power-up accepted while blocked");
   lp_default_a: assert property (pin_low_load |-> ##[0:2] o_low_power_off_state)
      else $error("low-power off not entered by default");
   pd_exclusive_a: assert property (o_pd_request |-> !o_low_power_off_state)
      else $error("power-down request while off");
endmodule : puqoc_ctrl_checker
bind puqoc_ctrl puqoc_ctrl_checker #(.FUSE_LOAD_CYCLES(FUSE_LOAD_CYCLES)) puqoc_ctrl_checker_inst (.*);
`default_nettype wire

// ===== puqoc_system_model.sv
// system side model: supply comparator, overvoltage comparator, power-on pin
`default_nettype none
module puqoc_system_model (
   input wire logic i_core_clk, // core clock
   output logic o_supply, // supply above operate threshold
   output logic o_ov, // supply above lockout
   output logic o_pin // power-on pin level
);
   timeunit 1ns;
   timeprecision 1ps;
   // supply absent and pin low at power application
   initial begin
      o_supply = 1'b0;
      o_ov = 1'b0;
      o_pin = 1'b0;
   end
   // each change lands just after a clock edge
   task automatic supply(input logic v);
      @(posedge i_core_clk);
      o_supply <= v;
   endtask : supply
   task automatic ov(input logic v);
      @(posedge i_core_clk);
      o_ov <= v;
   endtask : ov
   // level mode: the pin level itself is the request
   task automatic pin(input logic v);
      @(posedge i_core_clk);
      o_pin <= v;
   endtask : pin
   // edge mode: fall, stay low n cycles, then release high
   task automatic pin_low_for(input int n);
      @(posedge i_core_clk);
      o_pin <= 1'b0;
      repeat (n) @(posedge i_core_clk);
      o_pin <= 1'b1;
   endtask : pin_low_for
endmodule : puqoc_system_model
`default_nettype wire

// ===== puqoc_ctrl_bench.sv
// self-checking bench for power-up qualification and overvoltage lockout
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
   $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module puqoc_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import puqoc_pkg::*;
   logic clk = 1'b0; // 40 MHz
   logic rst_n = 1'b0; // reset, active low
   logic sup, ov, pin; // driven by the system model
   logic [3:0] blk = 4'h0; // thermal, trim, fuse, self-test blockers
   logic pd_done = 1'b0; // power-down finished
   puqoc_fuse_t fz = 5'h10; // fuse contents
   logic [7:0] addr = 8'h0; // bus address
   logic [31:0] wdata = 32'h0; // bus write data
   logic wr_s = 1'b0, rd_s = 1'b0; // bus strobes
   logic [31:0] rdata; // bus read data
   logic loaded, seq, pd, lp, irq; // block outputs
   int err_count = 0, comparisons = 0; // tallies
   logic [31:0] d; // last word read
   int n; // cycles waited
   always #12.5 clk = ~clk;
   puqoc_system_model puqoc_system_model_inst (.i_core_clk(clk), .o_supply(sup), .o_ov(ov),
      .o_pin(pin));
   // short fuse read and debounce; self-test long enough for an abort
   puqoc_ctrl #(.FUSE_LOAD_CYCLES(4), .SELFTEST_CYCLES(600), .POWER_ON_DEBOUNCE_TIME_CYCLES(20))
   puqoc_ctrl_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_supply_operate_threshold(sup),
      .i_input_overvoltage_lockout(ov), .i_thermal_shutdown(blk[0]), .i_power_on_pin(pin),
      .i_fuse(fz), .i_trim_error_flag(blk[1]), .i_fuse_error_flag(blk[2]),
      .i_selftest_error_flag(blk[3]), .i_pd_done(pd_done), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .o_fuse_loaded(loaded), .o_seq_start(seq),
      .o_pd_request(pd), .o_low_power_off_state(lp), .o_irq(irq));
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr
   // read data is only valid in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask : rd
   // wait for seq (0), loaded (1) or irq (2), bounded by lim
   task automatic wait_hi(input int sel, input int lim);
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while ((sel == 0 ? seq : sel == 1 ? loaded : irq) !== 1'b1 && n < lim);
   endtask : wait_hi
   // power cycle with new fuses; fuse-loaded flag must stay low while unpowered
   task automatic power(input puqoc_fuse_t f);
      puqoc_system_model_inst.supply(1'b0);
      repeat (10) @(posedge clk);
      `CHK("unpowered", 1'b0, loaded)
      fz <= f;
      puqoc_system_model_inst.supply(1'b1);
      wait_hi(1, 200);
      `CHK("fuse loaded", 1'b1, loaded)
   endtask : power
   task automatic t_boot();
      power(5'h14);
      `CHK("low_power_off_state default", 1'b1, lp)
      rd(ADDR_CTRL);
      `CHK("ctrl defaults", 5'h09, d[4:0])
      // unmapped addresses read as zero
      rd(8'hf3);
      `CHK("unmapped read", 32'h0, d)
      puqoc_system_model_inst.pin(1'b1);
      wait_hi(0, 32000);
      `CHK("slot after pin", 1'b1, seq)
      // reserved upper bits written as ones must read back as zero
      wr(ADDR_CTRL, 32'hffff_fff1);
      rd(ADDR_CTRL);
      `CHK("lp flag written", 32'h11, d)
   endtask : t_boot
   task automatic t_ov_run();
      wr(ADDR_MASK, 32'h1);
      wr(ADDR_IRQ, 32'h7);
      puqoc_system_model_inst.ov(1'b1);
      repeat (450) @(posedge clk);
      #1 `CHK("ov irq", 1'b1, irq)
      `CHK("ov keeps running", 1'b0, pd)
      puqoc_system_model_inst.ov(1'b0);
      wr(ADDR_IRQ, 32'h1);
      wr(ADDR_CTRL, 32'h10);
      // let the filter fall first, or the next rise is no new edge
      repeat (450) @(posedge clk);
      puqoc_system_model_inst.ov(1'b1);
      repeat (450) @(posedge clk);
      #1 `CHK("monitor off", 1'b0, irq)
      puqoc_system_model_inst.ov(1'b0);
      repeat (450) @(posedge clk);
   endtask : t_ov_run
   // filter length per code; the 1000 and reserved codes must not fire within 4500 cycles
   task automatic t_debounce();
      int exp;
      for (int c = 0; c < 4; c++) begin
         exp = (c == 0) ? 400 : (c == 1) ? 4000 : 0;
         wr(ADDR_CTRL, {27'h0, 1'b1, 2'(c), 2'h1});
         wr(ADDR_IRQ, 32'h7);
         puqoc_system_model_inst.ov(1'b1);
         wait_hi(2, 4500);
         if (exp > 0) `CHK("debounce length", 1'b1, n >= exp && n <= exp + 12)
         else `CHK("long debounce", 1'b0, irq)
         puqoc_system_model_inst.ov(1'b0);
         repeat (4500) @(posedge clk);
      end
      wr(ADDR_CTRL, 32'h13);
      puqoc_system_model_inst.ov(1'b1);
      repeat (450) @(posedge clk);
      #1 `CHK("ov shutdown", 1'b1, pd)
      puqoc_system_model_inst.ov(1'b0);
      pd_done <= 1'b1;
      @(posedge clk);
      pd_done <= 1'b0;
   endtask : t_debounce
   task automatic t_block();
      puqoc_system_model_inst.pin(1'b0);
      power(5'h18);
      for (int i = 0; i < 5; i++) begin
         blk <= (i < 4) ? 4'(1 << i) : 4'h0;
         if (i == 4) puqoc_system_model_inst.ov(1'b1);
         repeat (450) @(posedge clk);
         puqoc_system_model_inst.pin(1'b1);
         wait_hi(0, 300);
         `CHK("power-up refused", 1'b0, seq)
         `CHK("still off", 1'b1, lp)
         puqoc_system_model_inst.pin(1'b0);
         puqoc_system_model_inst.ov(1'b0);
      end
      blk <= 4'h0;
      repeat (450) @(posedge clk);
      puqoc_system_model_inst.pin(1'b1);
      puqoc_system_model_inst.ov(1'b1);
      wait_hi(0, 1200);
      `CHK("startup aborted", 1'b0, seq)
      `CHK("back to off", 1'b1, lp)
      rd(ADDR_IRQ);
      `CHK("abort irq", 1'b1, d[IRQ_ABORT])
      puqoc_system_model_inst.ov(1'b0);
      puqoc_system_model_inst.pin(1'b0);
      // filter survives a power cycle; let it fall so a fresh edge follows
      repeat (450) @(posedge clk);
      power(5'h10);
      puqoc_system_model_inst.pin(1'b1);
      puqoc_system_model_inst.ov(1'b1);
      wait_hi(0, 1200);
      `CHK("startup continues", 1'b1, seq)
      rd(ADDR_IRQ);
      `CHK("ov reported", 1'b1, d[IRQ_OV])
      puqoc_system_model_inst.ov(1'b0);
   endtask : t_block
   // edge mode: a short low glitch is no event, a held low one is
   task automatic t_edge();
      power(5'h11);
      puqoc_system_model_inst.pin_low_for(3);
      wait_hi(0, 200);
      `CHK("glitch ignored", 1'b0, seq)
      `CHK("glitch still off", 1'b1, lp)
      puqoc_system_model_inst.pin_low_for(40);
      wait_hi(0, 1200);
      `CHK("held low event", 1'b1, seq)
   endtask : t_edge
   // pin already high: first slot bounded from the supply crossing
   task automatic t_first();
      fz <= 5'h12;
      puqoc_system_model_inst.supply(1'b0);
      repeat (10) @(posedge clk);
      puqoc_system_model_inst.supply(1'b1);
      wait_hi(0, 60000);
      `CHK("slot from supply", 1'b1, seq)
   endtask : t_first
   task automatic complete_run();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_boot();
      t_ov_run();
      t_debounce();
      t_block();
      t_edge();
      t_first();
      complete_run();
   end
   // watchdog sized well above the expected run length
   initial begin
      repeat (90000) @(posedge clk);
      err_count++;
      complete_run();
   end
endmodule : puqoc_ctrl_bench
`default_nettype wire
